// >>> hw/bsi_pkg.sv
package bsi_pkg;

  localparam int unsigned BSI_BSR_LEN = 132;
  localparam int unsigned BSI_IR_W    = 3;

  localparam logic [2:0] BSI_IR_EXTEST = 3'h0;
  localparam logic [2:0] BSI_IR_SAMPLE = 3'h1;
  localparam logic [2:0] BSI_IR_FLOAT  = 3'h4;
  localparam logic [2:0] BSI_IR_RESET  = 3'h7;

  localparam logic [1:0] BSI_IR_CAPTURE_LOW = 2'h1;

  localparam logic [2:0] BSI_TMS_RESET_EDGES = 3'h5;

  typedef enum logic [3:0] {
    BSI_TLR,
    BSI_IDLE,
    BSI_SEL_DR,
    BSI_CAP_DR,
    BSI_SH_DR,
    BSI_EX1_DR,
    BSI_PAU_DR,
    BSI_EX2_DR,
    BSI_UPD_DR,
    BSI_SEL_IR,
    BSI_CAP_IR,
    BSI_SH_IR,
    BSI_EX1_IR,
    BSI_PAU_IR,
    BSI_EX2_IR,
    BSI_UPD_IR
  } bsi_tap_e;

endpackage

// >>> hw/bsi_tap.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Code 001 places the 132-bit boundary register between data in and out.
// - Sample/preload captures system pin values at capture-DR on TCK rise.
// - Shifting the snapshot never disturbs system operation or driven pins.
// - Preload fills boundary output bits before external test takes effect.
// - Codes X1X and 101 select the one-bit bypass path.
// - Bypass stage loads zero at capture-DR, so first bit out is zero.
// - Code 100 floats every output driver and selects bypass.
// - Power-on reset clears both system and scan logic.
// - During power-on reset the controller stays in test-logic-reset.
// - Five consecutive TMS-high TCK rises force test-logic-reset.
// - Undriven or high TMS keeps test-logic-reset; TMS and TDI idle high.
// - TCK still clocks in low-power halt; leaving reset only costs power.
// - 3-bit instruction register updates only in update-IR, presets to ones.
// - Capture-IR loads 01 low and crystal missing flag into bit 2.
// - Code 000 selects boundary register and holds system logic in reset.
module bsi_tap
  import bsi_pkg::*;
#(
  parameter int unsigned BSR_LEN = BSI_BSR_LEN
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  input  wire logic [BSR_LEN-1:0] sys_capture_i,
  input  wire logic               crystal_missing_flag_i,
  input  wire logic               low_power_halt_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_n_o,
  output logic [BSR_LEN-1:0]      bsr_out_o,
  output logic                    pin_drive_o,
  output logic                    outputs_float_instruction_o,
  output logic                    sys_reset_o,
  output logic                    min_power_o
);

  typedef struct packed {
    logic [2:0]         tck_s;
    logic [2:0]         tms_s;
    logic [2:0]         tdi_s;
    logic               tck_lvl;
    logic               tms_lvl;
    logic               tdi_lvl;
    bsi_tap_e           tap;
    logic [2:0]         tms_run;
    logic [2:0]         ir_sh;
    logic [2:0]         ir_q;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               byp;
    logic               tdo;
    logic               tdo_oe_n;
    logic               pin_drive;
    logic               float_out;
    logic               sys_reset;
    logic               min_power;
  } bsi_state_s;

  bsi_state_s q;
  bsi_state_s d;
  logic       rise;
  logic       fall;
  logic       adv;
  logic       bsr_sel;

  // Edges counted only once stages two and three agree
  assign rise    = q.tck_s[1] & q.tck_s[2] & ~q.tck_lvl;
  assign fall    = ~q.tck_s[1] & ~q.tck_s[2] & q.tck_lvl;
  assign adv     = ce_i & rise;
  assign bsr_sel = (q.ir_q == BSI_IR_EXTEST) || (q.ir_q == BSI_IR_SAMPLE);

  always_comb
  begin
    d = q;
    d.tck_s = {q.tck_s[1:0], tck_i};
    d.tms_s = {q.tms_s[1:0], tms_i};
    d.tdi_s = {q.tdi_s[1:0], tdi_i};
    if (q.tck_s[1] == q.tck_s[2])
    begin
      d.tck_lvl = q.tck_s[1];
    end
    if (q.tms_s[1] == q.tms_s[2])
    begin
      d.tms_lvl = q.tms_s[1];
    end
    if (q.tdi_s[1] == q.tdi_s[2])
    begin
      d.tdi_lvl = q.tdi_s[1];
    end
    if (rise)
    begin
      // Controller steps on TCK rise only
      unique case (q.tap)
        BSI_TLR:    d.tap = q.tms_lvl ? BSI_TLR : BSI_IDLE;
        BSI_IDLE:   d.tap = q.tms_lvl ? BSI_SEL_DR : BSI_IDLE;
        BSI_SEL_DR: d.tap = q.tms_lvl ? BSI_SEL_IR : BSI_CAP_DR;
        BSI_CAP_DR: d.tap = q.tms_lvl ? BSI_EX1_DR : BSI_SH_DR;
        BSI_SH_DR:  d.tap = q.tms_lvl ? BSI_EX1_DR : BSI_SH_DR;
        BSI_EX1_DR: d.tap = q.tms_lvl ? BSI_UPD_DR : BSI_PAU_DR;
        BSI_PAU_DR: d.tap = q.tms_lvl ? BSI_EX2_DR : BSI_PAU_DR;
        BSI_EX2_DR: d.tap = q.tms_lvl ? BSI_UPD_DR : BSI_SH_DR;
        BSI_UPD_DR: d.tap = q.tms_lvl ? BSI_SEL_DR : BSI_IDLE;
        BSI_SEL_IR: d.tap = q.tms_lvl ? BSI_TLR : BSI_CAP_IR;
        BSI_CAP_IR: d.tap = q.tms_lvl ? BSI_EX1_IR : BSI_SH_IR;
        BSI_SH_IR:  d.tap = q.tms_lvl ? BSI_EX1_IR : BSI_SH_IR;
        BSI_EX1_IR: d.tap = q.tms_lvl ? BSI_UPD_IR : BSI_PAU_IR;
        BSI_PAU_IR: d.tap = q.tms_lvl ? BSI_EX2_IR : BSI_PAU_IR;
        BSI_EX2_IR: d.tap = q.tms_lvl ? BSI_UPD_IR : BSI_SH_IR;
        BSI_UPD_IR: d.tap = q.tms_lvl ? BSI_SEL_DR : BSI_IDLE;
      endcase
      // Run length of TMS high, helper for the reset check
      if (!q.tms_lvl)
      begin
        d.tms_run = '0;
      end
      else if (q.tms_run != BSI_TMS_RESET_EDGES)
      begin
        d.tms_run = q.tms_run + 3'h1;
      end
      unique case (q.tap)
        BSI_CAP_IR: d.ir_sh = {crystal_missing_flag_i, BSI_IR_CAPTURE_LOW};
        BSI_SH_IR:  d.ir_sh = {q.tdi_lvl, q.ir_sh[2:1]};
        BSI_UPD_IR: d.ir_q = q.ir_sh;
        BSI_CAP_DR:
        begin
          if (bsr_sel)
          begin
            d.bsr_sh = sys_capture_i;
          end
          else
          begin
            d.byp = 1'b0;
          end
        end
        BSI_SH_DR:
        begin
          if (bsr_sel)
          begin
            d.bsr_sh = {q.tdi_lvl, q.bsr_sh[BSR_LEN-1:1]};
          end
          else
          begin
            d.byp = q.tdi_lvl;
          end
        end
        // Preload lands here ahead of external
        BSI_UPD_DR:
        begin
          if (bsr_sel)
          begin
            d.bsr_upd = q.bsr_sh;
          end
        end
        default:
        begin
        end
      endcase
    end
    if (fall)
    begin
      // TDO moves on TCK fall, driven only while shifting
      d.tdo_oe_n = ~((q.tap == BSI_SH_DR) || (q.tap == BSI_SH_IR));
      if (q.tap == BSI_SH_IR)
      begin
        d.tdo = q.ir_sh[0];
      end
      else
      begin
        d.tdo = bsr_sel ? q.bsr_sh[0] : q.byp;
      end
    end
    // Instruction preset while in test-logic-reset
    if (d.tap == BSI_TLR)
    begin
      d.ir_q = BSI_IR_RESET;
    end
    d.pin_drive = (d.ir_q == BSI_IR_EXTEST);
    d.float_out = (d.ir_q == BSI_IR_FLOAT);
    d.sys_reset = (d.ir_q == BSI_IR_EXTEST);
    // Halt is not blocked; only power saving is lost outside reset
    d.min_power = low_power_halt_i & (d.tap == BSI_TLR);
  end

  // Power-on reset is the async reset of the whole port
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q          <= '0;
      // Levels start high like the pulled-up pins, so no false edge follows reset
      q.tck_s    <= 3'h7;
      q.tms_s    <= 3'h7;
      q.tdi_s    <= 3'h7;
      q.tck_lvl  <= 1'b1;
      q.tms_lvl  <= 1'b1;
      q.tdi_lvl  <= 1'b1;
      q.tap      <= BSI_TLR;
      q.ir_q     <= BSI_IR_RESET;
      q.ir_sh    <= BSI_IR_RESET;
      q.tdo_oe_n <= 1'b1;
      q.tdo      <= 1'b1;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign tdo_o                       = q.tdo;
  assign tdo_oe_n_o                  = q.tdo_oe_n;
  assign bsr_out_o                   = q.bsr_upd;
  assign pin_drive_o                 = q.pin_drive;
  assign outputs_float_instruction_o = q.float_out;
  assign sys_reset_o                 = q.sys_reset;
  assign min_power_o                 = q.min_power;

  property p_ir_capture;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (adv && q.tap == BSI_CAP_IR) |=> (q.ir_sh == {$past(crystal_missing_flag_i), BSI_IR_CAPTURE_LOW});
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("capture-IR value wrong");

  property p_ir_preset;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.tap == BSI_TLR) |-> (q.ir_q == BSI_IR_RESET);
  endproperty
  a_ir_preset: assert property (p_ir_preset) else $error("instruction not preset in reset state");

  property p_ir_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!(adv && q.tap == BSI_UPD_IR) && d.tap != BSI_TLR) |=> $stable(q.ir_q);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside update-IR");

  property p_byp_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (adv && q.tap == BSI_CAP_DR && !bsr_sel) |=> !q.byp;
  endproperty
  a_byp_zero: assert property (p_byp_zero) else $error("bypass did not capture zero");

  property p_bsr_capture;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (adv && q.tap == BSI_CAP_DR && bsr_sel) |=> (q.bsr_sh == $past(sys_capture_i));
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("boundary snapshot wrong");

  property p_upd_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !(adv && q.tap == BSI_UPD_DR) |=> $stable(q.bsr_upd);
  endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("pin values disturbed by shift");

  property p_five_tms;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.tms_run == BSI_TMS_RESET_EDGES) |-> (q.tap == BSI_TLR);
  endproperty
  a_five_tms: assert property (p_five_tms) else $error("five TMS highs did not reset");

  property p_float;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    outputs_float_instruction_o == (q.ir_q == BSI_IR_FLOAT);
  endproperty
  a_float: assert property (p_float) else $error("float output mismatch");

  property p_sys_reset;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (sys_reset_o == (q.ir_q == BSI_IR_EXTEST)) && (pin_drive_o == sys_reset_o);
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("external test reset mismatch");

  property p_tdo_fall;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !(ce_i && fall) |=> ($stable(tdo_o) && $stable(tdo_oe_n_o));
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("TDO changed off a falling edge");

  property p_tdo_oe;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && fall) |=> (tdo_oe_n_o != (($past(q.tap) == BSI_SH_DR) || ($past(q.tap) == BSI_SH_IR)));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("TDO enable outside shift states");

  property p_min_power;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i |=> (min_power_o == ($past(low_power_halt_i) && (q.tap == BSI_TLR)));
  endproperty
  a_min_power: assert property (p_min_power) else $error("power saving status wrong");

  c_sample: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    adv && q.tap == BSI_CAP_DR && q.ir_q == BSI_IR_SAMPLE);
  c_float: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) outputs_float_instruction_o);
  c_extest: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) adv && q.tap == BSI_UPD_DR && pin_drive_o);
  c_bypass: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) adv && q.tap == BSI_CAP_DR && !bsr_sel);
  c_five_tms: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) q.tms_run == BSI_TMS_RESET_EDGES);

endmodule

`default_nettype wire

// >>> tb/bsi_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bsi_tester (
  input  wire logic ref_clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  // Between frames the clock stands high; data lines start at pull-up level
  initial
  begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // Edges placed on ref_clk: own synchronisation so snapshots mean something
  // Never enables device outputs, so no contention on driven nets
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    @(posedge ref_clk_i) #1;
    tms_o = tms;
    tdi_o = tdi;
    tck_o = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 tck_o = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    // The value launched by this call's fall; its rise has not landed yet
    #1 tdo = tdo_i;
  endtask
endmodule
`default_nettype wire

// >>> tb/bsi_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bsi_tap_tb_top;
  import bsi_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst_n   = 1'b0;
  logic         flag    = 1'b0;
  logic         halt    = 1'b0;
  logic         ce      = 1'b1;
  logic [131:0] cap     = '0;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         oe_n;
  logic [131:0] bsr;
  logic         drv;
  logic         flt;
  logic         srst;
  logic         minp;
  int           n_errors = 0;
  int           checked  = 0;
  int           seed     = 91;

  always #20 ref_clk = ~ref_clk;

  bsi_tap i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .sys_capture_i(cap), .crystal_missing_flag_i(flag), .low_power_halt_i(halt), .tdo_o(tdo),
    .tdo_oe_n_o(oe_n), .bsr_out_o(bsr), .pin_drive_o(drv), .outputs_float_instruction_o(flt),
    .sys_reset_o(srst), .min_power_o(minp));
  bsi_tester i_ctl (.ref_clk_i(ref_clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  function automatic logic [131:0] rnd();
    logic [159:0] v;
    v = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    return v[131:0];
  endfunction

  // Last accepted TCK rise lands one edge after the tester returns
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Arguments are copied at the call, so settle beforehand
  task automatic chk(input string nm, input logic [131:0] exp, input logic [131:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // From Idle: select, capture, shift n bits LSB first, update, back to Idle
  task automatic scan(input bit ir, input int n, input logic [131:0] din, output logic [131:0] dout);
    logic t;
    i_ctl.bit_io(1'b1, 1'b1, t);
    if (ir)
      i_ctl.bit_io(1'b1, 1'b1, t);
    i_ctl.bit_io(1'b0, 1'b1, t);
    i_ctl.bit_io(1'b0, 1'b1, t);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      i_ctl.bit_io(i == n - 1, din[i], dout[i]);
      if (i == 0)
        chk("oe_n_shift", 0, oe_n);
    end
    i_ctl.bit_io(1'b1, 1'b1, t);
    i_ctl.bit_io(1'b0, 1'b1, t);
  endtask

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    results();
  end

  initial
  begin
    logic [131:0] din;
    logic [131:0] dout;
    logic [131:0] exp_bsr;
    logic [2:0]   codes [8];
    logic         c;
    // Preload before external test, then every other code
    codes = '{3'h1, 3'h0, 3'h4, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("oe_n", 1, oe_n);
    chk("bsr_out", 0, bsr);
    chk("sys_reset", 0, srst);
    $display("Test reset done");
    exp_bsr = '0;
    i_ctl.bit_io(1'b0, 1'b1, c);
    foreach (codes[k])
    begin
      cap = rnd();
      din = rnd();
      flag = cap[7];
      scan(1, 3, {129'h0, codes[k]}, dout);
      chk("ir_capture", {129'h0, flag, 2'b01}, dout);
      settle();
      chk("pin_drive", codes[k] == 3'h0, drv);
      chk("sys_reset", codes[k] == 3'h0, srst);
      chk("float", codes[k] == 3'h4, flt);
      chk("preload", exp_bsr, bsr);
      scan(0, 132, din, dout);
      chk("dr_out", (codes[k] < 3'h2) ? cap : {din[130:0], 1'b0}, dout);
      if (codes[k] < 3'h2)
        exp_bsr = din;
      settle();
      chk("bsr_after", exp_bsr, bsr);
      chk("sys_reset_after", codes[k] == 3'h0, srst);
      $display("Test code %h done", codes[k]);
    end
    scan(1, 3, 132'h4, dout);
    i_ctl.bit_io(1'b1, 1'b1, c);
    i_ctl.bit_io(1'b0, 1'b1, c);
    i_ctl.bit_io(1'b0, 1'b1, c);
    repeat (4) i_ctl.bit_io(1'b1, 1'b1, c);
    chk("float_four", 1, flt);
    i_ctl.bit_io(1'b1, 1'b1, c);
    settle();
    chk("float_five", 0, flt);
    $display("Test five edges done");
    i_ctl.bit_io(1'b0, 1'b1, c);
    scan(1, 3, 132'h0, dout);
    halt = 1'b1;
    settle();
    chk("sys_reset_set", 1, srst);
    @(posedge ref_clk) #1 rst_n = 1'b0;
    settle();
    chk("sys_reset_por", 0, srst);
    i_ctl.bit_io(1'b0, 1'b1, c);
    i_ctl.bit_io(1'b0, 1'b1, c);
    @(posedge ref_clk) #1 rst_n = 1'b1;
    settle();
    chk("min_power_por", 1, minp);
    i_ctl.bit_io(1'b0, 1'b1, c);
    settle();
    chk("min_power_idle", 0, minp);
    chk("sys_reset_idle", 0, srst);
    repeat (6) i_ctl.bit_io(1'b1, 1'b1, c);
    chk("min_power_tms", 1, minp);
    // Enable low freezes the port, so this TMS-low edge is lost
    ce = 1'b0;
    i_ctl.bit_io(1'b0, 1'b1, c);
    ce = 1'b1;
    settle();
    chk("min_power_frozen", 1, minp);
    $display("Test power on and halt done");
    results();
  end
endmodule
`default_nettype wire
